// file: ihcp_pkg.sv
// Behaviour
// - Drive three-bit register address to drive
// - Low command-block select for command registers
// - Low control-block select for control registers
// - Address by select plus address, or acknowledge
// - Low acknowledge marks strobe as DMA data
// - DMA pair serves only bus-master function
// - Read strobe lets drive talk; capture on release
// - Write data held under strobe; drive latches release
// - Channel-ready low stretches PIO strobe
// - Burst write data on both strobe edges
// - Burst read paused by deasserting host ready
// - Stop on write-strobe pin ends burst
// - Burst read captures both channel-ready edges
// - Burst write pauses while channel-ready low
package ihcp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int T_SETUP_NS = 70;
    localparam int T_STROBE_NS = 165;
    localparam int T_RECOVER_NS = 30;
    localparam int T_BURST_SETUP_NS = 20;
    localparam int TMR_W = 8;
    // Least times, so rounded up to whole cycles
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int BURST_CYC = (T_BURST_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [TMR_W-1:0] SETUP_CNT = TMR_W'(SETUP_CYC);
    localparam logic [TMR_W-1:0] STROBE_CNT = TMR_W'(STROBE_CYC);
    localparam logic [TMR_W-1:0] RECOVER_CNT = TMR_W'(RECOVER_CYC);
    localparam logic [TMR_W-1:0] BURST_CNT = TMR_W'(BURST_CYC);
    localparam logic [1:0] MODE_PIO = 2'h0;
    localparam logic [1:0] MODE_MWDMA = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    localparam logic [2:0] ADDR_RST = 3'h0;
    localparam logic [15:0] DATA_RST = 16'h0000;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_STROBE = 7'h04,
        ST_RECOVER = 7'h08,
        ST_BURST_RD = 7'h10,
        ST_BURST_WR = 7'h20,
        ST_BURST_STOP = 7'h40
    } ihcp_state_type;
endpackage

// file: ihcp_timer.sv
`timescale 1ns/1ns
module ihcp_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] cycles_i,
    output logic done_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Loading N holds done low for the next N-1 cycles
    assign count_next = load_i ? cycles_i - WIDTH'(1) :
                        (count_reg != '0) ? count_reg - WIDTH'(1) : count_reg;
    assign done_o = (count_reg == '0);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // ihcp_timer

// file: ihcp_port.sv
`timescale 1ns/1ns
module ihcp_port (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [1:0] mode_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_dma_i,
    input wire logic req_ctrl_blk_i,
    input wire logic [2:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic burst_start_i,
    input wire logic burst_write_i,
    input wire logic burst_pause_i,
    input wire logic burst_stop_i,
    output logic rsp_valid_o,
    output logic [15:0] rsp_rdata_o,
    output logic busy_o,
    output logic [2:0] dev_addr_o,
    output logic cmd_block_cs_n_o,
    output logic ctrl_block_cs_n_o,
    output logic dma_ack_n_o,
    input wire logic dma_req_i,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    input wire logic chan_ready_i,
    input wire logic [15:0] disk_data_i,
    output logic [15:0] disk_data_o,
    output logic disk_data_oe_n_o
);
    ////////////////////////////////////////////////////////////////////////
    ihcp_pkg::ihcp_state_type state_reg, state_next;
    logic [2:0] addr_reg, addr_next;
    logic cs1_n_reg, cs1_n_next;
    logic cs3_n_reg, cs3_n_next;
    logic ack_n_reg, ack_n_next;
    logic rd_pin_reg, rd_pin_next;
    logic wr_pin_reg, wr_pin_next;
    logic [15:0] dout_reg, dout_next;
    logic oe_n_reg, oe_n_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rsp_reg, rsp_next;
    logic write_reg, write_next;
    logic pend_reg, pend_next;
    logic rdy_prev_reg;
    logic tmr_load;
    logic [ihcp_pkg::TMR_W-1:0] tmr_val;
    logic tmr_done;

    ////////////////////////////////////////////////////////////////////////
    wire is_idle = (state_reg == ihcp_pkg::ST_IDLE);
    wire is_burst = (mode_i == ihcp_pkg::MODE_BURST);
    wire is_pio = (mode_i == ihcp_pkg::MODE_PIO);
    // DMA words wait for the drive's request; register access does not
    wire cycle_ok = !req_dma_i || dma_req_i;
    wire cycle_take = is_idle && !is_burst && req_valid_i && cycle_ok;
    wire burst_take = is_idle && is_burst && burst_start_i && dma_req_i;
    // Burst word accepted only with the drive ready and no word in flight
    wire bwr_ready = (state_reg == ihcp_pkg::ST_BURST_WR) && !pend_reg &&
                     tmr_done && chan_ready_i && dma_req_i &&
                     !burst_stop_i;
    wire bwr_take = bwr_ready && req_valid_i;
    // Strobe may end once minimum width met and, in PIO, ready is back
    wire strobe_end = tmr_done && (chan_ready_i || !is_pio);
    // Each level change of channel-ready is a data strobe
    wire rdy_edge = (chan_ready_i != rdy_prev_reg);
    wire burst_end = burst_stop_i || !dma_req_i;

    assign req_ready_o = (is_idle && !is_burst && cycle_ok) || bwr_ready;
    assign busy_o = !is_idle;
    assign rsp_valid_o = rsp_reg;
    assign rsp_rdata_o = rdata_reg;
    assign dev_addr_o = addr_reg;
    assign cmd_block_cs_n_o = cs1_n_reg;
    assign ctrl_block_cs_n_o = cs3_n_reg;
    assign dma_ack_n_o = ack_n_reg;
    assign read_strobe_n_o = rd_pin_reg;
    assign write_strobe_n_o = wr_pin_reg;
    assign disk_data_o = dout_reg;
    assign disk_data_oe_n_o = oe_n_reg;

    ihcp_timer #(
        .WIDTH(ihcp_pkg::TMR_W)
    ) u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(tmr_load),
        .cycles_i(tmr_val),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        cs1_n_next = cs1_n_reg;
        cs3_n_next = cs3_n_reg;
        ack_n_next = ack_n_reg;
        rd_pin_next = rd_pin_reg;
        wr_pin_next = wr_pin_reg;
        dout_next = dout_reg;
        oe_n_next = oe_n_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        write_next = write_reg;
        pend_next = pend_reg;
        tmr_load = 1'b0;
        tmr_val = ihcp_pkg::SETUP_CNT;
        unique case (state_reg)
            ihcp_pkg::ST_IDLE: begin
                if (cycle_take) begin
                    write_next = req_write_i;
                    tmr_load = 1'b1;
                    state_next = ihcp_pkg::ST_SETUP;
                    if (req_dma_i) begin
                        ack_n_next = 1'b0;
                    end else begin
                        addr_next = req_addr_i;
                        cs1_n_next = req_ctrl_blk_i;
                        cs3_n_next = !req_ctrl_blk_i;
                    end
                    if (req_write_i) begin
                        dout_next = req_wdata_i;
                        oe_n_next = 1'b0;
                    end
                end else if (burst_take) begin
                    ack_n_next = 1'b0;
                    wr_pin_next = 1'b0;
                    write_next = burst_write_i;
                    pend_next = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = ihcp_pkg::BURST_CNT;
                    if (burst_write_i) begin
                        rd_pin_next = 1'b1;
                        oe_n_next = 1'b0;
                        state_next = ihcp_pkg::ST_BURST_WR;
                    end else begin
                        rd_pin_next = burst_pause_i;
                        state_next = ihcp_pkg::ST_BURST_RD;
                    end
                end
            end
            ihcp_pkg::ST_SETUP: begin
                if (tmr_done) begin
                    rd_pin_next = write_reg;
                    wr_pin_next = !write_reg;
                    tmr_load = 1'b1;
                    tmr_val = ihcp_pkg::STROBE_CNT;
                    state_next = ihcp_pkg::ST_STROBE;
                end
            end
            ihcp_pkg::ST_STROBE: begin
                if (strobe_end) begin
                    rd_pin_next = 1'b1;
                    wr_pin_next = 1'b1;
                    // Taken as the strobe rises; the drive still holds data
                    if (!write_reg) begin
                        rdata_next = disk_data_i;
                        rsp_next = 1'b1;
                    end
                    tmr_load = 1'b1;
                    tmr_val = ihcp_pkg::RECOVER_CNT;
                    state_next = ihcp_pkg::ST_RECOVER;
                end
            end
            ihcp_pkg::ST_RECOVER: begin
                if (tmr_done) begin
                    cs1_n_next = 1'b1;
                    cs3_n_next = 1'b1;
                    ack_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    state_next = ihcp_pkg::ST_IDLE;
                end
            end
            ihcp_pkg::ST_BURST_RD: begin
                rd_pin_next = burst_pause_i;
                if (rdy_edge) begin
                    rdata_next = disk_data_i;
                    rsp_next = 1'b1;
                end
                if (burst_end) begin
                    wr_pin_next = 1'b1;
                    state_next = ihcp_pkg::ST_BURST_STOP;
                end
            end
            ihcp_pkg::ST_BURST_WR: begin
                if (bwr_take) begin
                    dout_next = req_wdata_i;
                    pend_next = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = ihcp_pkg::BURST_CNT;
                end else if (pend_reg && tmr_done && chan_ready_i) begin
                    // Each strobe edge, either direction, carries one word
                    rd_pin_next = !rd_pin_reg;
                    pend_next = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = ihcp_pkg::BURST_CNT;
                end else if (!pend_reg && burst_end) begin
                    wr_pin_next = 1'b1;
                    state_next = ihcp_pkg::ST_BURST_STOP;
                end
            end
            ihcp_pkg::ST_BURST_STOP: begin
                // Acknowledge held until the drive drops its request
                if (!dma_req_i) begin
                    ack_n_next = 1'b1;
                    wr_pin_next = 1'b1;
                    rd_pin_next = 1'b1;
                    oe_n_next = 1'b1;
                    state_next = ihcp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = ihcp_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ihcp_pkg::ST_IDLE;
            addr_reg <= ihcp_pkg::ADDR_RST;
            cs1_n_reg <= 1'b1;
            cs3_n_reg <= 1'b1;
            ack_n_reg <= 1'b1;
            rd_pin_reg <= 1'b1;
            wr_pin_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            cs1_n_reg <= cs1_n_next;
            cs3_n_reg <= cs3_n_next;
            ack_n_reg <= ack_n_next;
            rd_pin_reg <= rd_pin_next;
            wr_pin_reg <= wr_pin_next;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_reg <= ihcp_pkg::DATA_RST;
            oe_n_reg <= 1'b1;
            rdata_reg <= ihcp_pkg::DATA_RST;
            rsp_reg <= 1'b0;
            write_reg <= 1'b0;
            pend_reg <= 1'b0;
            rdy_prev_reg <= 1'b1;
        end else begin
            dout_reg <= dout_next;
            oe_n_reg <= oe_n_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
            write_reg <= write_next;
            pend_reg <= pend_next;
            rdy_prev_reg <= chan_ready_i;
        end
    end
endmodule // ihcp_port

// file: ihcp_port_chk.sv
`timescale 1ns/1ns
module ihcp_port_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [1:0] mode_i,
    input wire logic burst_pause_i,
    input wire logic burst_stop_i,
    input wire logic rsp_valid_o,
    input wire logic [15:0] rsp_rdata_o,
    input wire logic [2:0] dev_addr_o,
    input wire logic cmd_block_cs_n_o,
    input wire logic ctrl_block_cs_n_o,
    input wire logic dma_ack_n_o,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic chan_ready_i,
    input wire logic [15:0] disk_data_i,
    input wire logic [15:0] disk_data_o,
    input wire logic disk_data_oe_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire brst = (mode_i == ihcp_pkg::MODE_BURST);
    wire pio = (mode_i == ihcp_pkg::MODE_PIO);
    wire sel = !cmd_block_cs_n_o || !ctrl_block_cs_n_o;
    ////////////////////////////////////////////////////////////////////////
    a_one_target: assert property (
        !(sel && !dma_ack_n_o) && (cmd_block_cs_n_o || ctrl_block_cs_n_o))
        else $error("selects overlap");
    a_addr_hold: assert property (sel && $past(sel) |->
        $stable(dev_addr_o) && $stable({cmd_block_cs_n_o, ctrl_block_cs_n_o}))
        else $error("address moved under select");
    a_read_width: assert property (rsp_valid_o && !brst |->
        read_strobe_n_o && $past(read_strobe_n_o, 42) == 1'b0)
        else $error("read word without full strobe");
    a_read_float: assert property (
        !read_strobe_n_o && !brst |-> disk_data_oe_n_o)
        else $error("host drives bus during read");
    a_write_drive: assert property (!write_strobe_n_o && !brst |->
        !disk_data_oe_n_o && $stable(disk_data_o))
        else $error("write data not held");
    a_ready_wait: assert property (pio &&
        ($rose(read_strobe_n_o) || $rose(write_strobe_n_o)) |->
        $past(chan_ready_i))
        else $error("PIO strobe ended while drive not ready");
    a_stop_bound: assert property (
        brst && !dma_ack_n_o && burst_stop_i |-> ##[1:40] write_strobe_n_o)
        else $error("burst stop missing");
    a_pause_follow: assert property (brst && !dma_ack_n_o &&
        !$past(dma_ack_n_o) && disk_data_oe_n_o && !write_strobe_n_o &&
        !$past(write_strobe_n_o) |->
        read_strobe_n_o == $past(burst_pause_i))
        else $error("host ready not following pause");
    a_burst_cap: assert property (brst && rsp_valid_o |->
        $past(chan_ready_i) != $past(chan_ready_i, 2) &&
        rsp_rdata_o == $past(disk_data_i))
        else $error("burst word without strobe edge");
    a_write_hold: assert property (brst && !disk_data_oe_n_o &&
        !$past(disk_data_oe_n_o) && !dma_ack_n_o &&
        read_strobe_n_o != $past(read_strobe_n_o) |->
        $past(chan_ready_i) && $stable(disk_data_o))
        else $error("burst write edge while drive not ready");
    c_pio_read: cover property (rsp_valid_o && !brst);
    c_burst_read: cover property (rsp_valid_o && brst);
    c_burst_stop: cover property (brst && $rose(write_strobe_n_o));
endmodule // ihcp_port_chk
bind ihcp_port ihcp_port_chk chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .mode_i(mode_i),
    .burst_pause_i(burst_pause_i),
    .burst_stop_i(burst_stop_i),
    .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o),
    .dev_addr_o(dev_addr_o),
    .cmd_block_cs_n_o(cmd_block_cs_n_o),
    .ctrl_block_cs_n_o(ctrl_block_cs_n_o),
    .dma_ack_n_o(dma_ack_n_o),
    .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .chan_ready_i(chan_ready_i),
    .disk_data_i(disk_data_i),
    .disk_data_o(disk_data_o),
    .disk_data_oe_n_o(disk_data_oe_n_o)
);

// file: ihcp_drive.sv
`timescale 1ns/1ns
module ihcp_drive (
    input wire logic clock_i,
    input wire logic [1:0] mode_i,
    input wire logic req_on_i,
    input wire logic slow_i,
    input wire logic [15:0] rd_word_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic dma_ack_n_i,
    input wire logic disk_data_oe_n_i,
    output logic dma_req_o,
    output logic chan_ready_o,
    output logic [15:0] disk_data_o
);
    logic [15:0] word = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic rdy = 1'b1;
    wire burst = mode_i == 2'h2 && !dma_ack_n_i;
    wire brd = burst && disk_data_oe_n_i && !write_strobe_n_i;
    wire bwr = burst && !disk_data_oe_n_i;
    wire rd = mode_i != 2'h2 && !read_strobe_n_i && disk_data_oe_n_i;
    wire strb = !read_strobe_n_i || !write_strobe_n_i;
    assign dma_req_o = req_on_i;
    assign chan_ready_o = rdy;
    // Released bus shows the inverse word, so a stale value never matches
    assign disk_data_o = (rd || brd) ? word : ~word;
    always @(posedge clock_i) begin
        cnt <= cnt + 4'h1;
        if (!burst && read_strobe_n_i) begin
            word <= rd_word_i;
        end
        if (brd) begin
            if (!read_strobe_n_i && cnt[0]) begin
                rdy <= ~rdy;
                word <= word + 16'h1;
            end
        end else if (bwr) begin
            rdy <= !(slow_i && cnt[3:2] == 2'h0);
        end else begin
            rdy <= !(slow_i && strb && cnt != 4'hf);
        end
    end
endmodule // ihcp_drive

// file: testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module testbench;
    logic clock_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0;
    logic req_dma_i = 0, req_ctrl_blk_i = 0, burst_start_i = 0;
    logic burst_write_i = 0, burst_pause_i = 0, burst_stop_i = 0;
    logic req_on = 0, slow = 0, pr = 1, pw = 1;
    logic [1:0] mode_i = 0;
    logic [2:0] req_addr_i = 0, dev_addr_o;
    logic [15:0] req_wdata_i = 0, rd_word = 0, exp_w = 0, v, pq;
    logic [15:0] rsp_rdata_o, disk_data_o, disk_data_i;
    logic req_ready_o, rsp_valid_o, busy_o, cmd_block_cs_n_o, dma_ack_n_o;
    logic ctrl_block_cs_n_o, read_strobe_n_o, write_strobe_n_o;
    logic disk_data_oe_n_o, dma_req_i, chan_ready_i;
    int fails = 0, total_checks = 0, cyc = 0, k;
    logic [15:0] bq[$];
    always #2 clock_i = ~clock_i;
    ihcp_port dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_write_i(req_write_i), .req_dma_i(req_dma_i),
        .req_ctrl_blk_i(req_ctrl_blk_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .burst_start_i(burst_start_i),
        .burst_write_i(burst_write_i), .burst_pause_i(burst_pause_i),
        .burst_stop_i(burst_stop_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .dev_addr_o(dev_addr_o),
        .cmd_block_cs_n_o(cmd_block_cs_n_o),
        .ctrl_block_cs_n_o(ctrl_block_cs_n_o), .dma_ack_n_o(dma_ack_n_o),
        .dma_req_i(dma_req_i), .read_strobe_n_o(read_strobe_n_o),
        .write_strobe_n_o(write_strobe_n_o), .chan_ready_i(chan_ready_i),
        .disk_data_i(disk_data_i), .disk_data_o(disk_data_o),
        .disk_data_oe_n_o(disk_data_oe_n_o)
    );
    ihcp_drive drv (.clock_i(clock_i), .mode_i(mode_i), .req_on_i(req_on),
        .slow_i(slow), .rd_word_i(rd_word), .read_strobe_n_i(read_strobe_n_o),
        .write_strobe_n_i(write_strobe_n_o), .dma_ack_n_i(dma_ack_n_o),
        .disk_data_oe_n_i(disk_data_oe_n_o), .dma_req_o(dma_req_i),
        .chan_ready_o(chan_ready_i), .disk_data_o(disk_data_i));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] sel_exp(input logic d, input logic c);
        return d ? 3'h6 : (c ? 3'h5 : 3'h3);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    // Words are judged where the strobe moves, as the drive would latch them
    always @(negedge clock_i) begin
        if (mode_i == 2'h2 && !disk_data_oe_n_o &&
            pr !== read_strobe_n_o) begin
            // Popped once here, as the compare macro reads its operand twice
            pq = bq.pop_front();
            `CHK(disk_data_o, pq)
        end
        if (mode_i != 2'h2 && !pw && write_strobe_n_o)
            `CHK(disk_data_o, exp_w)
        pr = read_strobe_n_o;
        pw = write_strobe_n_o;
    end
    task automatic take();
        int n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 200);
        `CHK(req_ready_o, 1'b1)
        @(posedge clock_i);
        req_valid_i <= 0;
    endtask
    task automatic access(input logic w, d, c, input logic [2:0] a, input s);
        int r = 0;
        logic [5:0] pins;
        @(posedge clock_i);
        exp_w = 16'($urandom);
        slow <= s;
        rd_word <= 16'($urandom);
        req_valid_i <= 1;
        req_write_i <= w;
        req_dma_i <= d;
        req_ctrl_blk_i <= c;
        req_addr_i <= a;
        req_wdata_i <= exp_w;
        take();
        for (int n = 0; n < 400; n++) begin
            @(negedge clock_i);
            if (rsp_valid_o === 1'b1) begin
                r++;
                `CHK(rsp_rdata_o, rd_word)
                // Cycle n + 1 counted from the take edge
                `CHK(n >= ihcp_pkg::SETUP_CYC + ihcp_pkg::STROBE_CYC, 1'b1)
            end
            if (!read_strobe_n_o || !write_strobe_n_o) begin
                pins = {cmd_block_cs_n_o, ctrl_block_cs_n_o, dma_ack_n_o,
                    dev_addr_o};
                `CHK(pins, {sel_exp(d, c), d ? dev_addr_o : a})
            end
            if (busy_o === 1'b0)
                break;
        end
        `CHK(busy_o, 1'b0)
        `CHK(r, w ? 0 : 1)
    endtask
    task automatic start_burst(input logic w);
        @(posedge clock_i);
        mode_i <= 2'h2;
        req_on <= 1;
        slow <= w;
        rd_word <= 16'hfffd;
        burst_write_i <= w;
        burst_start_i <= 1;
        for (int n = 0; n < 20 && busy_o !== 1'b1; n++)
            @(negedge clock_i);
        `CHK(busy_o, 1'b1)
        @(posedge clock_i);
        burst_start_i <= 0;
    endtask
    task automatic end_burst();
        @(posedge clock_i);
        burst_pause_i <= 0;
        burst_stop_i <= 1;
        for (int n = 0; n < 60 && write_strobe_n_o !== 1'b1; n++)
            @(negedge clock_i);
        `CHK(write_strobe_n_o, 1'b1)
        @(posedge clock_i);
        req_on <= 0;
        for (int n = 0; n < 60 && busy_o !== 1'b0; n++)
            @(negedge clock_i);
        `CHK(busy_o, 1'b0)
        @(posedge clock_i);
        burst_stop_i <= 0;
    endtask
    initial begin
        void'($urandom(31));
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1;
        @(negedge clock_i);
        `CHK({cmd_block_cs_n_o, ctrl_block_cs_n_o, dma_ack_n_o, busy_o},
            4'he)
        access(1'b1, 1'b0, 1'b1, 3'h7, 1'b1);
        for (int i = 0; i < 6; i++)
            access(1'($urandom), 1'b0, i[1], 3'($urandom), i[0]);
        @(posedge clock_i);
        mode_i <= 2'h1;
        req_dma_i <= 1;
        @(negedge clock_i);
        `CHK(req_ready_o, 1'b0)
        @(posedge clock_i);
        req_on <= 1;
        access(1'b0, 1'b1, 1'b0, 3'h0, 1'b0);
        access(1'b1, 1'b1, 1'b0, 3'h0, 1'b0);
        start_burst(1'b0);
        k = 0;
        for (int n = 0; n < 300 && k < 6; n++) begin
            @(posedge clock_i);
            burst_pause_i <= n > 8 && n < 20;
            @(negedge clock_i);
            if (rsp_valid_o === 1'b1) begin
                k++;
                `CHK(rsp_rdata_o, 16'hfffd + 16'(k))
            end
        end
        `CHK(k, 6)
        end_burst();
        start_burst(1'b1);
        for (int i = 0; i < 4; i++) begin
            v = i == 0 ? 16'hffff : 16'($urandom);
            bq.push_back(v);
            @(posedge clock_i);
            req_valid_i <= 1;
            req_wdata_i <= v;
            take();
        end
        for (int n = 0; n < 100 && bq.size() > 0; n++)
            @(negedge clock_i);
        `CHK(bq.size(), 0)
        end_burst();
        tally_and_finish();
    end
endmodule // testbench
